// file: hw/rrx_decode.sv
// Opcode classifier for the return/rotate executor
`timescale 1ns/100ps
`include "rrx_map.svh"
module rrx_decode
    import rrx_pkg::*;
(
    // Instruction word
    input wire logic [13:0] instr,
    // Classification
    output rrx_op_t op
);
    always_comb
    begin
        if (instr == `RRX_OP_RETURN)
            op = RRX_RETURN;
        else if (instr == `RRX_OP_RETINT)
            op = RRX_RETINT;
        else if ((instr[13:10] & `RRX_LITRET_MASK) == (`RRX_LITRET_HI & `RRX_LITRET_MASK)
                 && instr[13:12] == 2'h3 && instr[11:10] == 2'h1)
            op = RRX_LITRET;
        else if (instr[13:8] == `RRX_ROTL_HI)
            op = RRX_ROTL;
        else
            op = RRX_NONE;
    end
endmodule : rrx_decode

// file: hw/rrx_exec.sv
// Executor for return, interrupt return, literal return and rotate left
`timescale 1ns/100ps
`include "rrx_map.svh"
// What this block does
// - Subroutine return pops stack into program counter; status flags untouched.
// - Subroutine return takes two cycles; second cycle idle while pipeline refills.
// - Rotate left: old carry into bit 0, old bit 7 into carry.
// - Destination bit 0 writes working register, 1 writes file register.
// - Interrupt return pops stack into counter, sets global interrupt enable, two cycles.
module rrx_exec
    import rrx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    output logic instr_ready,
    // Stack push from call logic
    input wire logic push_en,
    input wire logic [12:0] push_pc,
    // File register access
    output logic [6:0] file_addr,
    input wire logic [7:0] file_rdata,
    output logic file_we,
    output logic [7:0] file_wdata,
    // Core state
    output logic [12:0] pc,
    output logic pc_load,
    output logic [7:0] w_reg,
    output logic carry,
    output logic global_interrupt_enable,
    output logic [12:0] stack_top_entry
);
    // ==========================================================
    // Decode
    rrx_op_t op;
    rrx_decode u_dec (.instr(instr), .op(op));

    // ==========================================================
    // State
    typedef enum logic [0:0] {ST_RUN, ST_IDLE} rrx_st_t;
    rrx_st_t st_r, st_nxt;
    // Eight-entry return stack; the pointer wraps on overflow and underflow
    logic [12:0] stk_r [`RRX_STACK_DEPTH];
    logic [12:0] stk_nxt [`RRX_STACK_DEPTH];
    logic [2:0] sp_r, sp_nxt;
    logic [12:0] pc_r, pc_nxt;
    logic [7:0] w_r, w_nxt;
    logic c_r, c_nxt;
    logic gie_r, gie_nxt;
    logic ld_r, ld_nxt;
    logic we_r, we_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic take, pop;
    logic [8:0] rot;

    assign instr_ready = (st_r == ST_RUN);
    assign take = instr_valid && instr_ready;
    assign pop = take && (op == RRX_RETURN || op == RRX_RETINT || op == RRX_LITRET);
    assign file_addr = instr[6:0];
    assign rot = {file_rdata, c_r};

    always_comb
    begin
        st_nxt = st_r;
        sp_nxt = sp_r;
        pc_nxt = pc_r;
        w_nxt = w_r;
        c_nxt = c_r;
        gie_nxt = gie_r;
        ld_nxt = 1'b0;
        we_nxt = 1'b0;
        wd_nxt = wd_r;
        for (int i = 0; i < `RRX_STACK_DEPTH; i++)
            stk_nxt[i] = stk_r[i];
        if (st_r == ST_IDLE)
            st_nxt = ST_RUN;
        else if (take)
        begin
            case (op)
                RRX_RETURN, RRX_RETINT, RRX_LITRET:
                begin
                    pc_nxt = stk_r[sp_r - 3'h1];
                    sp_nxt = sp_r - 3'h1;
                    ld_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                    if (op == RRX_RETINT)
                        gie_nxt = 1'b1;
                    if (op == RRX_LITRET)
                        w_nxt = instr[7:0];
                end
                RRX_ROTL:
                begin
                    c_nxt = rot[8];
                    if (instr[`RRX_DEST_BIT])
                    begin
                        we_nxt = 1'b1;
                        wd_nxt = rot[7:0];
                    end
                    else
                        w_nxt = rot[7:0];
                end
                default:
                begin
                end
            endcase
        end
        // A push that meets a pop is dropped so the popped entry stays coherent
        if (push_en && !pop)
        begin
            stk_nxt[sp_r] = push_pc;
            sp_nxt = sp_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            st_r <= ST_RUN;
            sp_r <= 3'h0;
            pc_r <= 13'h0000;
            w_r <= 8'h00;
            c_r <= 1'b0;
            gie_r <= 1'b0;
            ld_r <= 1'b0;
            we_r <= 1'b0;
            wd_r <= 8'h00;
            for (int i = 0; i < `RRX_STACK_DEPTH; i++)
                stk_r[i] <= 13'h0000;
        end
        else
        begin
            st_r <= st_nxt;
            sp_r <= sp_nxt;
            pc_r <= pc_nxt;
            w_r <= w_nxt;
            c_r <= c_nxt;
            gie_r <= gie_nxt;
            ld_r <= ld_nxt;
            we_r <= we_nxt;
            wd_r <= wd_nxt;
            for (int i = 0; i < `RRX_STACK_DEPTH; i++)
                stk_r[i] <= stk_nxt[i];
        end
    end

    assign pc = pc_r;
    assign pc_load = ld_r;
    assign w_reg = w_r;
    assign carry = c_r;
    assign global_interrupt_enable = gie_r;
    assign file_we = we_r;
    assign file_wdata = wd_r;
    assign stack_top_entry = stk_r[sp_r - 3'h1];

    // ==========================================================
    // Checks
    a_ret_pc_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_RETURN |=> pc_load && pc == $past(stack_top_entry))
        else $error("return did not load stack top");
    a_ret_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_RETURN |=> $stable(carry) && $stable(global_interrupt_enable))
        else $error("return changed flags");
    a_pop_depth: assert property (@(posedge clk_sys) disable iff (!resetn)
        pop |=> sp_r == $past(sp_r) - 3'h1)
        else $error("pop did not lower stack pointer");

    a_ret_two_cyc: assert property (@(posedge clk_sys) disable iff (!resetn)
        pop |=> !instr_ready ##1 instr_ready)
        else $error("return not two cycles");
    a_idle_no_op: assert property (@(posedge clk_sys) disable iff (!resetn)
        !instr_ready |=> !pc_load && !file_we && $stable(w_reg) && $stable(carry)
            && $stable(pc))
        else $error("idle cycle changed state");

    a_rot_carry: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_ROTL |=> carry == $past(file_rdata[7]))
        else $error("rotate carry wrong");
    a_rot_gie: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_ROTL |=> $stable(global_interrupt_enable) && !pc_load && instr_ready)
        else $error("rotate touched more than carry");

    a_rot_to_w: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_ROTL && !instr[7]
        |=> !file_we && w_reg == {$past(file_rdata[6:0]), $past(carry)})
        else $error("rotate to working register wrong");
    a_rot_to_f: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_ROTL && instr[7]
        |=> file_we && file_wdata == {$past(file_rdata[6:0]), $past(carry)}
            && $stable(w_reg))
        else $error("rotate to file register wrong");

    a_retint_gie: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_RETINT |=> global_interrupt_enable && pc_load ##1 instr_ready)
        else $error("interrupt return wrong");
    a_retint_pc: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_RETINT |=> pc == $past(stack_top_entry) && $stable(carry))
        else $error("interrupt return did not load stack top");

    a_litret_w: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_LITRET |=> w_reg == $past(instr[7:0]) && pc_load
            ##1 !pc_load)
        else $error("literal return wrong");
    a_litret_pc: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_LITRET |=> pc == $past(stack_top_entry) && $stable(carry)
            && $stable(global_interrupt_enable))
        else $error("literal return did not load stack top");

    a_push_top: assert property (@(posedge clk_sys) disable iff (!resetn)
        push_en && !pop |=> stack_top_entry == $past(push_pc))
        else $error("push did not reach stack top");
    a_unknown_op: assert property (@(posedge clk_sys) disable iff (!resetn)
        take && op == RRX_NONE |=> instr_ready && !pc_load && !file_we && $stable(w_reg)
            && $stable(carry) && $stable(pc))
        else $error("unknown opcode changed state");

    // ==========================================================
    // Cover points
    c_return: cover property (@(posedge clk_sys) take && op == RRX_RETURN);
    c_retint: cover property (@(posedge clk_sys) take && op == RRX_RETINT);
    c_litret: cover property (@(posedge clk_sys) take && op == RRX_LITRET);
    c_rotl_f: cover property (@(posedge clk_sys) take && op == RRX_ROTL && instr[7]);
    c_rotl_w: cover property (@(posedge clk_sys) take && op == RRX_ROTL && !instr[7]);
endmodule : rrx_exec

// file: pkg/rrx_map.svh
// Opcode encodings, field positions and sizes for the return/rotate executor
`ifndef RRX_MAP_SVH
`define RRX_MAP_SVH
`define RRX_OP_RETURN 14'h0008
`define RRX_OP_RETINT 14'h0009
`define RRX_LITRET_HI 4'hd
`define RRX_LITRET_MASK 4'hc
`define RRX_ROTL_HI 6'h0d
`define RRX_DEST_BIT 7
`define RRX_GIE_BIT 7
`define RRX_STACK_DEPTH 8
`define RRX_PC_W 13
`define RRX_CYC_RETURN 2
`endif

// file: pkg/rrx_pkg.sv
// Types shared by the return/rotate executor
package rrx_pkg;
    typedef enum logic [2:0] {
        RRX_NONE,
        RRX_RETURN,
        RRX_RETINT,
        RRX_LITRET,
        RRX_ROTL
    } rrx_op_t;
endpackage : rrx_pkg

// file: verif/rrx_exec_test.sv
// Directed testbench for the return/rotate executor
`timescale 1ns/100ps
module rrx_exec_test;
    // ==========================================================
    // Clock, reset and design hookup
    logic clk_sys;
    logic resetn;
    logic instr_valid;
    logic [13:0] instr;
    logic instr_ready;
    logic push_en;
    logic [12:0] push_pc;
    logic [6:0] file_addr;
    logic [7:0] file_rdata;
    logic file_we;
    logic [7:0] file_wdata;
    logic [12:0] pc;
    logic pc_load;
    logic [7:0] w_reg;
    logic carry;
    logic global_interrupt_enable;
    logic [12:0] stack_top_entry;
    int miscompares = 0;
    int tests_run = 0;

    rrx_exec dut (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .push_en(push_en), .push_pc(push_pc),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
        .file_wdata(file_wdata), .pc(pc), .pc_load(pc_load), .w_reg(w_reg),
        .carry(carry), .global_interrupt_enable(global_interrupt_enable),
        .stack_top_entry(stack_top_entry));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // Valid stays up so rotates can follow back to back
    task automatic issue(input logic [13:0] op, input logic [7:0] rd);
        instr = op;
        file_rdata = rd;
        instr_valid = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : issue

    task automatic push(input logic [12:0] v);
        push_pc = v;
        push_en = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        push_en = 1'b0;
        // One quiet edge so back-to-back pushes never meet in one step
        @(negedge clk_sys);
    endtask : push

    // ==========================================================
    // Scenarios
    task automatic t_returns();
        push(13'h0123);
        push(13'h0456);
        chk(stack_top_entry, 16'h0456);
        issue(14'h0008, 8'h00);
        instr_valid = 1'b0;
        chk(pc, 16'h0456);
        chk(pc_load, 16'h0001);
        chk(instr_ready, 16'h0000);
        chk(carry, 16'h0000);
        chk(stack_top_entry, 16'h0123);
        @(negedge clk_sys);
        chk(instr_ready, 16'h0001);
        chk(pc_load, 16'h0000);
        issue(14'h0009, 8'h00);
        instr_valid = 1'b0;
        chk(pc, 16'h0123);
        chk(global_interrupt_enable, 16'h0001);
        chk(instr_ready, 16'h0000);
        @(negedge clk_sys);
        push(13'h0777);
        issue(14'h3455, 8'h00);
        instr_valid = 1'b0;
        chk(w_reg, 16'h0055);
        chk(pc, 16'h0777);
        chk(instr_ready, 16'h0000);
        @(negedge clk_sys);
    endtask : t_returns

    task automatic t_rotate();
        issue(14'h0d85, 8'h80);
        chk(file_addr, 16'h0005);
        chk(file_we, 16'h0001);
        chk(file_wdata, 16'h0000);
        chk(carry, 16'h0001);
        issue(14'h0d05, 8'he6);
        chk(file_we, 16'h0000);
        chk(w_reg, 16'h00cd);
        chk(carry, 16'h0001);
        issue(14'h0d05, 8'h41);
        instr_valid = 1'b0;
        chk(w_reg, 16'h0083);
        chk(carry, 16'h0000);
        chk(global_interrupt_enable, 16'h0001);
    endtask : t_rotate

    // Return keeps flags set earlier; an unknown opcode is ignored
    task automatic t_flags();
        issue(14'h0d85, 8'h80);
        instr_valid = 1'b0;
        chk(carry, 16'h0001);
        push(13'h0abc);
        chk(stack_top_entry, 16'h0abc);
        issue(14'h0000, 8'hff);
        issue(14'h0008, 8'h00);
        instr_valid = 1'b0;
        chk(pc, 16'h0abc);
        chk(carry, 16'h0001);
        chk(global_interrupt_enable, 16'h0001);
        chk(w_reg, 16'h0083);
        @(negedge clk_sys);
    endtask : t_flags

    // ==========================================================
    // Main sequence and hang guard
    initial
    begin
        resetn = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        push_en = 1'b0;
        push_pc = 13'h0000;
        file_rdata = 8'h00;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        chk(instr_ready, 16'h0001);
        chk(pc, 16'h0000);
        t_returns();
        t_rotate();
        t_flags();
        wrap_up();
    end

    initial
    begin
        #50000;
        miscompares++;
        wrap_up();
    end
endmodule : rrx_exec_test
